/* File: ldsr_bank.sv */
// Identity and sink current level registers with mode masking
`timescale 1ns/1ns
module ldsr_bank
  import ldsr_pkg::*;
#(
  parameter logic [4:0] IDENT = IDENT_DEFAULT,
  parameter logic [2:0] CHIP_REV = REV_DEFAULT
)
(
  ldsr_reg_if.bank bus
);
  logic [7:0] level_r;
  logic [7:0] level_nxt;
  logic [7:0] sink_r;
  logic [7:0] sink_nxt;
  logic [7:0] rd_word;

  // ----------------------------------------
  // Next values
  // ----------------------------------------
  always_comb
  begin
    level_nxt = level_r;
    // Identity and unmapped writes fall through untouched
    if (bus.wr && (bus.ptr == LVL_OFS))
    begin
      level_nxt = bus.wdata;
    end
    case (bus.mode)
      MODE_ASSIST: sink_nxt = level_r & ASSIST_MASK;
      MODE_IND: sink_nxt = level_r & IND_MASK;
      default: sink_nxt = level_r;
    endcase
  end

  always_comb
  begin
    rd_word = UNMAPPED_RD;
    if (bus.ptr == ID_OFS)
    begin
      rd_word[REV_LSB +: REV_W] = CHIP_REV;
      rd_word[IDENT_LSB +: IDENT_W] = IDENT;
    end
    else if (bus.ptr == LVL_OFS)
    begin
      rd_word = level_r;
    end
  end

  assign bus.rdata = rd_word;
  assign bus.sink = sink_r;

  always_ff @(posedge bus.clk or negedge bus.rst_n)
  begin
    if (!bus.rst_n)
    begin
      level_r <= LVL_RST;
      sink_r <= SINK_RST;
    end
    else if (bus.ce)
    begin
      level_r <= level_nxt;
      sink_r <= sink_nxt;
    end
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge bus.clk);
  endclocking
  default disable iff (!bus.rst_n);

  lvl_reset_a: assert property ($rose(bus.rst_n) |-> level_r == LVL_RST)
    else $error("level not at reset value");
  rev_field_a: assert property ((bus.ptr == ID_OFS) |-> bus.rdata[2:0] == CHIP_REV)
    else $error("revision field wrong");
  ident_field_a: assert property ((bus.ptr == ID_OFS) |-> bus.rdata[7:3] == IDENT)
    else $error("identity field wrong");
  lvl_write_a: assert property ((bus.ce && bus.wr && bus.ptr == LVL_OFS) |=>
    (level_r == $past(bus.wdata)) ##1 (bus.ptr != LVL_OFS || rd_word == level_r))
    else $error("level write lost");
  id_write_a: assert property ((bus.wr && bus.ptr != LVL_OFS) |=> $stable(level_r))
    else $error("non level write changed level");
  assist_mask_a: assert property ((bus.ce && bus.mode == MODE_ASSIST) |=>
    sink_r == ($past(level_r) & 8'h7F))
    else $error("assist mask wrong");
  ind_mask_a: assert property ((bus.ce && bus.mode == MODE_IND) |=>
    sink_r == ($past(level_r) & 8'h3F) && sink_r <= 8'h3F)
    else $error("indicator mask wrong");
  full_code_a: assert property ((bus.ce && bus.mode != MODE_IND &&
    bus.mode != MODE_ASSIST) |=> sink_r == $past(level_r))
    else $error("full code not passed");
  assist_cov_c: cover property (bus.ce && bus.mode == MODE_ASSIST && level_r[7]);
endmodule

/* File: ldsr_bench.sv */
// Self-checking bench for the sink level register block
`timescale 1ns/1ns
module ldsr_bench;
  // Arbitrary identity and revision values
  localparam logic [4:0] IDV = 5'h0A;
  localparam logic [2:0] REV = 3'h5;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic ce = 1'b1;
  logic [1:0] mode = 2'h0;
  logic scl;
  logic sda;
  logic sda_oe;
  logic sda_o;
  logic [7:0] sink;
  logic [7:0] lv [2] = '{8'hC5, 8'hFF};
  logic [7:0] mx [2][4] = '{'{8'hC5, 8'h05, 8'h45, 8'hC5}, '{8'hFF, 8'h3F, 8'h7F, 8'hFF}};
  int miscompares = 0;
  int cmp_count = 0;
  int cyc = 0;

  ldsr_top #(.IDENT(IDV), .CHIP_REV(REV)) u_ldsr_top (.CLK(clk), .RSTN(rst_n), .CE(ce),
    .SCL_I(scl), .SDA_I(sda), .MODE_SEL(mode), .SDA_O(sda_o), .SDA_OE(sda_oe),
    .SINK_CODE(sink));
  ldsr_host u_ldsr_host (.clk(clk), .sda_oe(sda_oe), .sda_o(sda_o), .scl(scl), .sda(sda));

  initial forever #10 clk = ~clk;

  // ----
  // Checking and bus tasks
  // ----
  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  // Bounded run: all transfers need well under this many cycles
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      miscompares++;
      finish_test();
    end
  end

  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    cmp_count++;
    if (g !== e)
    begin
      miscompares++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic snd(input logic [7:0] d, input logic e);
    logic [7:0] q;
    logic ak;
    u_ldsr_host.byte_x(d, 1'b1, q, ak);
    chk("ack", {7'h0, e}, {7'h0, ak});
  endtask

  task automatic wr(input logic [7:0] p, d0, d1, input int n);
    u_ldsr_host.start();
    snd(8'h60, 1'b0);
    snd(p, 1'b0);
    snd(d0, 1'b0);
    if (n > 1) snd(d1, 1'b0);
    u_ldsr_host.stop();
  endtask

  task automatic rd(input logic [7:0] p, e0, e1, input int n);
    logic [7:0] q;
    logic ak;
    u_ldsr_host.start();
    snd(8'h60, 1'b0);
    snd(p, 1'b0);
    u_ldsr_host.start();
    snd(8'h61, 1'b0);
    u_ldsr_host.byte_x(8'hFF, n == 1, q, ak);
    chk("read", e0, q);
    if (n > 1)
    begin
      u_ldsr_host.byte_x(8'hFF, 1'b1, q, ak);
      chk("read next", e1, q);
    end
    u_ldsr_host.stop();
  endtask

  // Read one byte from wherever the pointer stands, without setting it first
  task automatic rd_cur(input logic [7:0] e);
    logic [7:0] q;
    logic ak;
    u_ldsr_host.start();
    snd(8'h61, 1'b0);
    u_ldsr_host.byte_x(8'hFF, 1'b1, q, ak);
    chk("current read", e, q);
    u_ldsr_host.stop();
  endtask

  task automatic sink_is(input logic [7:0] e);
    repeat (3) @(posedge clk);
    chk("sink code", e, sink);
  endtask

  // ----
  // Test sequence
  // ----
  initial
  begin
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    sink_is(8'h9C);
    chk("drive level", 8'h00, {7'h0, sda_o});
    rd(8'h01, 8'h9C, 8'h00, 1);
    rd(8'h00, {IDV, REV}, 8'h00, 1);
    $display("test reset values done");
    for (int l = 0; l < 2; l++)
    begin
      wr(8'h01, lv[l], 8'h00, 1);
      rd(8'h01, lv[l], 8'h00, 1);
      for (int m = 0; m < 4; m++)
      begin
        mode <= m[1:0];
        sink_is(mx[l][m]);
      end
      mode <= 2'h0;
    end
    $display("test mode masking done");
    wr(8'h00, 8'h00, 8'h77, 2);
    rd(8'h00, {IDV, REV}, 8'h77, 2);
    sink_is(8'h77);
    rd(8'h02, 8'h00, 8'h00, 1);
    $display("test identity write done");
    u_ldsr_host.start();
    snd(8'h62, 1'b1);
    snd(8'h01, 1'b1);
    snd(8'h11, 1'b1);
    u_ldsr_host.stop();
    sink_is(8'h77);
    wr(8'h01, 8'h00, 8'h00, 1);
    sink_is(8'h00);
    $display("test foreign address done");
    rst_n <= 1'b0;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    sink_is(8'h9C);
    rd_cur({IDV, REV});
    rd_cur(8'h9C);
    rd(8'h01, 8'h9C, 8'h00, 1);
    $display("test second reset done");
    // A low enable must hold the sink code even though the mode moves
    ce <= 1'b0;
    mode <= 2'h1;
    repeat (3) @(posedge clk);
    chk("frozen sink code", 8'h9C, sink);
    ce <= 1'b1;
    sink_is(8'h1C);
    mode <= 2'h0;
    $display("test clock enable done");
    finish_test();
  end
endmodule

/* File: ldsr_host.sv */
// Two-wire bus host model for the sink level block
`timescale 1ns/1ns
module ldsr_host
(
  input wire logic clk,
  input wire logic sda_oe,
  input wire logic sda_o,
  output logic scl,
  output logic sda
);
  // ----
  // Line levels
  // ----
  logic sda_m = 1'b1;
  initial scl = 1'b1;
  // Pull-up on the data line; a driving device puts its output value on it
  assign sda = sda_m & (~sda_oe | sda_o);

  task automatic wt(input int n);
    repeat (n) @(posedge clk);
  endtask

  // Data first raised while the clock is low, so no false stop is seen
  task automatic start();
    sda_m <= 1'b1;
    wt(2);
    scl <= 1'b1;
    wt(4);
    sda_m <= 1'b0;
    wt(4);
    scl <= 1'b0;
    wt(2);
  endtask

  task automatic stop();
    sda_m <= 1'b0;
    wt(3);
    scl <= 1'b1;
    wt(4);
    sda_m <= 1'b1;
    wt(4);
  endtask

  // Phases of 3 and 4 edges keep clear of the two-edge minimum
  task automatic bit_x(input logic b, output logic r);
    sda_m <= b;
    wt(3);
    scl <= 1'b1;
    wt(4);
    r = sda;
    scl <= 1'b0;
    wt(2);
  endtask

  // Eight bits MSB first, then the acknowledge slot
  task automatic byte_x(input logic [7:0] d, input logic a, output logic [7:0] q,
    output logic ak);
    logic r;
    for (int i = 7; i >= 0; i--)
    begin
      bit_x(d[i], r);
      q[i] = r;
    end
    bit_x(a, ak);
  endtask
endmodule

/* File: ldsr_pkg.sv */
// Package with offsets, field layout, reset values and states of the sink level block
package ldsr_pkg;
  localparam logic [6:0] DEV_ADDR = 7'h30;
  localparam logic [7:0] ID_OFS = 8'h00;
  localparam logic [7:0] LVL_OFS = 8'h01;
  localparam logic [7:0] LVL_RST = 8'h9C;
  localparam logic [7:0] SINK_RST = 8'h00;
  localparam logic [7:0] UNMAPPED_RD = 8'h00;
  localparam int REV_LSB = 0;
  localparam int REV_W = 3;
  localparam int IDENT_LSB = 3;
  localparam int IDENT_W = 5;
  // Arbitrary neutral values
  localparam logic [4:0] IDENT_DEFAULT = 5'h0D;
  localparam logic [2:0] REV_DEFAULT = 3'h1;
  localparam logic [1:0] MODE_IND = 2'h1;
  localparam logic [1:0] MODE_ASSIST = 2'h2;
  localparam logic [7:0] IND_MASK = 8'h3F;
  localparam logic [7:0] ASSIST_MASK = 8'h7F;
  localparam logic [2:0] LAST_BIT = 3'h7;
  typedef enum logic [9:0] {
    S_IDLE = 10'h001,
    S_ADDR = 10'h002,
    S_PTR = 10'h004,
    S_WR = 10'h008,
    S_ACK0 = 10'h010,
    S_ACK1 = 10'h020,
    S_RD = 10'h040,
    S_RACK0 = 10'h080,
    S_RACK = 10'h100,
    S_RNXT = 10'h200
  } ldsr_state_t;
endpackage

/* File: ldsr_reg_if.sv */
// Interface between the serial front end and the register bank
`timescale 1ns/1ns
interface ldsr_reg_if (
  input logic clk,
  input logic rst_n
);
  logic ce;
  logic [1:0] mode;
  logic [7:0] ptr;
  logic [7:0] wdata;
  logic wr;
  logic [7:0] rdata;
  logic [7:0] sink;
  modport ctl (input clk, input rst_n, output ce, output mode, output ptr, output wdata,
    output wr, input rdata, input sink);
  modport bank (input clk, input rst_n, input ce, input mode, input ptr, input wdata,
    input wr, output rdata, output sink);
endinterface

/* File: ldsr_top.sv */
// Two-wire serial slave front end with identity and sink current level registers
`timescale 1ns/1ns
// Functional notes
// - Address 0 bits 2:0 give chip revision
// - Address 0 bits 7:3 give constant identity
// - Address 1 is read/write combined sink code
// - Sink code register resets to 9Ch; SINK_CODE resets to 00h and follows it one enabled clock later
// - Assist mode uses only code bits 6:0
// - Indicator mode uses only code bits 5:0
// - Slave address 0110000, pointer auto-increments
module ldsr_top
  import ldsr_pkg::*;
#(
  parameter logic [4:0] IDENT = IDENT_DEFAULT,
  parameter logic [2:0] CHIP_REV = REV_DEFAULT
)
(
  input wire logic CLK,
  input wire logic RSTN,
  input wire logic CE,
  input wire logic SCL_I,
  input wire logic SDA_I,
  input wire logic [1:0] MODE_SEL,
  output logic SDA_O,
  output logic SDA_OE,
  output logic [7:0] SINK_CODE
);
  ldsr_reg_if bus (.clk(CLK), .rst_n(RSTN));

  ldsr_bank #(.IDENT(IDENT), .CHIP_REV(CHIP_REV)) u_bank (.bus(bus.bank));

  ldsr_state_t st_r;
  ldsr_state_t st_nxt;
  ldsr_state_t tgt_r;
  ldsr_state_t tgt_nxt;
  logic scl_q_r;
  logic sda_q_r;
  logic [7:0] sh_r;
  logic [7:0] sh_nxt;
  logic [2:0] cnt_r;
  logic [2:0] cnt_nxt;
  logic [7:0] ptr_r;
  logic [7:0] ptr_nxt;
  logic [7:0] wdata_r;
  logic [7:0] wdata_nxt;
  logic wr_r;
  logic wr_nxt;
  logic oe_r;
  logic oe_nxt;
  logic scl_rise;
  logic scl_fall;
  logic start_c;
  logic stop_c;
  logic [7:0] byte_in;

  // ----------------------------------------
  // Bus conditions
  // ----------------------------------------
  // Inputs are synchronous, so one stage of history is enough for edges
  assign scl_rise = SCL_I & ~scl_q_r;
  assign scl_fall = ~SCL_I & scl_q_r;
  assign start_c = scl_q_r & SCL_I & sda_q_r & ~SDA_I;
  assign stop_c = scl_q_r & SCL_I & ~sda_q_r & SDA_I;
  assign byte_in = {sh_r[6:0], SDA_I};

  // ----------------------------------------
  // Protocol engine
  // ----------------------------------------
  always_comb
  begin
    st_nxt = st_r;
    tgt_nxt = tgt_r;
    sh_nxt = sh_r;
    cnt_nxt = cnt_r;
    ptr_nxt = ptr_r;
    wdata_nxt = wdata_r;
    wr_nxt = 1'b0;
    oe_nxt = oe_r;
    if (wr_r)
    begin
      ptr_nxt = ptr_r + 8'h01;
    end
    if (start_c)
    begin
      st_nxt = S_ADDR;
      cnt_nxt = 3'h0;
      oe_nxt = 1'b0;
    end
    else if (stop_c)
    begin
      st_nxt = S_IDLE;
      oe_nxt = 1'b0;
    end
    else
    begin
      case (st_r)
        S_IDLE:
        begin
          oe_nxt = 1'b0;
        end
        S_ADDR, S_PTR, S_WR:
        begin
          if (scl_rise)
          begin
            sh_nxt = byte_in;
            cnt_nxt = cnt_r + 3'h1;
            if (cnt_r == LAST_BIT)
            begin
              st_nxt = S_ACK0;
              if (st_r == S_ADDR)
              begin
                // A foreign address leaves the bus alone until the next start
                if (byte_in[7:1] != DEV_ADDR)
                begin
                  st_nxt = S_IDLE;
                end
                tgt_nxt = byte_in[0] ? S_RNXT : S_PTR;
              end
              else if (st_r == S_PTR)
              begin
                ptr_nxt = byte_in;
                tgt_nxt = S_WR;
              end
              else
              begin
                // Every data byte is acknowledged, even for read-only targets
                wr_nxt = 1'b1;
                wdata_nxt = byte_in;
                tgt_nxt = S_WR;
              end
            end
          end
        end
        S_ACK0:
        begin
          if (scl_fall)
          begin
            oe_nxt = 1'b1;
            st_nxt = S_ACK1;
          end
        end
        S_ACK1:
        begin
          if (scl_fall)
          begin
            cnt_nxt = 3'h0;
            if (tgt_r == S_RNXT)
            begin
              sh_nxt = bus.rdata;
              oe_nxt = ~bus.rdata[7];
              st_nxt = S_RD;
            end
            else
            begin
              oe_nxt = 1'b0;
              st_nxt = tgt_r;
            end
          end
        end
        S_RD:
        begin
          if (scl_rise)
          begin
            cnt_nxt = cnt_r + 3'h1;
            if (cnt_r == LAST_BIT)
            begin
              ptr_nxt = ptr_r + 8'h01;
              st_nxt = S_RACK0;
            end
          end
          else if (scl_fall)
          begin
            sh_nxt = {sh_r[6:0], 1'b0};
            oe_nxt = ~sh_r[6];
          end
        end
        S_RACK0:
        begin
          if (scl_fall)
          begin
            oe_nxt = 1'b0;
            st_nxt = S_RACK;
          end
        end
        S_RACK:
        begin
          if (scl_rise)
          begin
            st_nxt = SDA_I ? S_IDLE : S_RNXT;
          end
        end
        S_RNXT:
        begin
          if (scl_fall)
          begin
            sh_nxt = bus.rdata;
            oe_nxt = ~bus.rdata[7];
            cnt_nxt = 3'h0;
            st_nxt = S_RD;
          end
        end
        default:
        begin
          st_nxt = S_IDLE;
          oe_nxt = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge CLK or negedge RSTN)
  begin
    if (!RSTN)
    begin
      st_r <= S_IDLE;
      tgt_r <= S_IDLE;
      scl_q_r <= 1'b1;
      sda_q_r <= 1'b1;
      sh_r <= 8'h00;
      cnt_r <= 3'h0;
      ptr_r <= 8'h00;
      wdata_r <= 8'h00;
      wr_r <= 1'b0;
      oe_r <= 1'b0;
    end
    else if (CE)
    begin
      st_r <= st_nxt;
      tgt_r <= tgt_nxt;
      scl_q_r <= SCL_I;
      sda_q_r <= SDA_I;
      sh_r <= sh_nxt;
      cnt_r <= cnt_nxt;
      ptr_r <= ptr_nxt;
      wdata_r <= wdata_nxt;
      wr_r <= wr_nxt;
      oe_r <= oe_nxt;
    end
  end

  // ----------------------------------------
  // Bank hookup and pins
  // ----------------------------------------
  assign bus.ce = CE;
  assign bus.mode = MODE_SEL;
  assign bus.ptr = ptr_r;
  assign bus.wdata = wdata_r;
  assign bus.wr = wr_r;
  // Open drain: the line is only ever pulled low
  assign SDA_O = 1'b0;
  assign SDA_OE = oe_r;
  assign SINK_CODE = bus.sink;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  ack_drive_a: assert property (@(posedge CLK) disable iff (!RSTN)
    (CE && st_r == S_ACK0 && scl_fall && !start_c && !stop_c) |=> oe_r && st_r == S_ACK1)
    else $error("acknowledge not driven");
  ptr_inc_a: assert property (@(posedge CLK) disable iff (!RSTN)
    (CE && wr_r) |=> ptr_r == $past(ptr_r) + 8'h01)
    else $error("pointer did not advance");
  addr_reject_a: assert property (@(posedge CLK) disable iff (!RSTN)
    (CE && st_r == S_ADDR && scl_rise && cnt_r == 3'h7 && byte_in[7:1] != 7'h30
    && !start_c && !stop_c) |=> st_r == S_IDLE && !oe_r)
    else $error("foreign address accepted");
  id_ack_a: assert property (@(posedge CLK) disable iff (!RSTN)
    (CE && wr_nxt && !wr_r) |=> st_r == S_ACK0 && wr_r)
    else $error("data byte not acknowledged");
  write_cov_c: cover property (@(posedge CLK) disable iff (!RSTN) wr_r && ptr_r == 8'h01);
  read_cov_c: cover property (@(posedge CLK) disable iff (!RSTN) st_r == S_RD && tgt_r == S_RNXT);
  id_write_cov_c: cover property (@(posedge CLK) disable iff (!RSTN) wr_r && ptr_r == 8'h00);
endmodule
